/* File: src/gii_pkg.sv */
// constants shared by the instrument bus interface
package gii_pkg;
  // ----
  // apb register map (byte addresses)
  // ----
  localparam logic [7:0] GII_CTRL_OFS   = 8'h00;
  localparam logic [7:0] GII_STATUS_OFS = 8'h04;
  localparam logic [7:0] GII_SETUP_OFS  = 8'h08;
  localparam logic [7:0] GII_TXDAT_OFS  = 8'h0C;
  localparam logic [7:0] GII_RXDAT_OFS  = 8'h10;
  localparam logic [7:0] GII_EVENT_OFS  = 8'h14;
  // ----
  // bus command bytes, received with atn true
  // ----
  localparam logic [7:0] GII_CMD_GTL = 8'h01;
  localparam logic [7:0] GII_CMD_SDC = 8'h04;
  localparam logic [7:0] GII_CMD_GET = 8'h08;
  localparam logic [7:0] GII_CMD_LLO = 8'h11;
  localparam logic [7:0] GII_CMD_DCL = 8'h14;
  localparam logic [7:0] GII_CMD_SPE = 8'h18;
  localparam logic [7:0] GII_CMD_SPD = 8'h19;
  localparam logic [7:0] GII_CMD_UNL = 8'h3F;
  localparam logic [7:0] GII_CMD_UNT = 8'h5F;
  localparam logic [7:0] GII_LAD_BASE = 8'h20;
  localparam logic [7:0] GII_TAD_BASE = 8'h40;
  // ----
  // status byte fields and ctrl register fields
  // ----
  localparam int GII_SB_RQS    = 7;
  localparam int GII_SB_INVAL  = 2;
  localparam int GII_SB_ERR    = 1;
  localparam int GII_SB_READY  = 0;
  localparam int GII_CTL_ADDR  = 0;  // 5-bit bus address
  localparam int GII_CTL_RDYEN = 8;  // ready enabled for service request
  localparam int GII_CTL_ERREN = 9;  // error enabled for service request
  localparam int GII_CTL_TRGM  = 12; // 2-bit trigger mode
  // ----
  // preset values applied on clear, plus the hold trigger mode and the reset srq selection
  // ----
  localparam logic [1:0]  GII_TRG_FREE   = 2'h0;
  localparam logic [1:0]  GII_TRG_HOLD   = 2'h1;
  localparam logic [19:0] GII_SRC_HZ_RST = 20'h003E8; // 1 kHz
  localparam logic [15:0] GII_SRC_MV_RST = 16'h0000;  // 0 mV
  localparam logic [3:0]  GII_MEAS_AC    = 4'h1;      // ac level
  localparam logic        GII_LP80_RST   = 1'b1;      // 80 kHz low-pass on
  localparam logic [7:0]  GII_SRQSEL_RST = 8'h22;     // condition state 22.2
  localparam logic [7:0]  GII_SRQSEL_DEF = 8'h00;
  // ----
  // handshake engine states
  // ----
  typedef enum logic [1:0] {
    GII_SH_IDLE = 2'b00,
    GII_SH_DAV  = 2'b01,
    GII_SH_WAIT = 2'b10
  } gii_sh_t;
endpackage

/* File: src/gii_ieee488_instrument_interface.sv */
// instrument-side ieee-488 interface message handler with apb registers
// Notes on behaviour
// R1: trigger in remote and listening starts one settled measurement.
// R2: bus trigger command and settled trigger code act identically.
// R3: clear presets source 1 kHz 0 mV, ac level, 80 kHz lp, free run.
// R4: clear zeroes status, withdraws request, cancels lockout, selects 22.2.
// R5: universal and addressed clear perform the same action.
// R6: remote entered only on listen address while remote enable true.
// R7: entering remote keeps settings, drops entry, disables most keys.
// R8: remote indicator lit only in the actual remote state.
// R9: go-to-local command or local key returns to local.
// R10: in local only free-run triggering is used.
// R11: lockout disables all keys including local and clear keys.
// R12: remote enable false returns to local and cancels lockout.
// R13: no controller function; bus control never taken or passed.
// R14: invalid program code always raises service request.
// R15: ready or error raises request only when enabled.
// R16: serial poll returns one status byte when talking; ended by disable.
// R17: while requesting, status bit 7 and cause bit are set.
// R18: status bits latched; clear after cause gone and byte read.
// R19: no parallel poll response is ever driven.
// R20: interface clear drops talker and listener states at once.
// R21: subsets sh1 ah1 t5 te0 l3 le0 sr1 rl1 pp0 dc1 dt1 c0.
// R22: when talking, results are offered except the blank display.
// R23: bytes are commands only while atn true and ifc false.
// R24: listener stays addressed until abort, own talk, or unlisten.
// R25: every byte uses the dav, nrfd, ndac three-wire handshake.
`timescale 1ns/1ns
module gii_ieee488_instrument_interface
  import gii_pkg::*;
#(
  parameter int DW = 8
)(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // ieee-488 bus, open-drain lines as in/out/enable
  input  wire logic [7:0]  i_dio,
  output logic      [7:0]  o_dio,
  output logic             o_dio_oe,
  input  wire logic        i_dav,
  output logic             o_dav_oe,
  input  wire logic        i_nrfd,
  output logic             o_nrfd_oe,
  input  wire logic        i_ndac,
  output logic             o_ndac_oe,
  input  wire logic        i_atn,
  input  wire logic        i_ifc,
  input  wire logic        i_ren,
  input  wire logic        i_eoi,
  output logic             o_srq_oe,
  // front panel and instrument side
  input  wire logic        i_return_to_local_key,
  input  wire logic        i_clear_key,
  input  wire logic        i_other_key,
  input  wire logic        i_meas_ready,
  input  wire logic        i_inst_error,
  input  wire logic        i_invalid_code,
  input  wire logic        i_settled_trigger_code,
  input  wire logic        i_blank_display,
  output logic             o_remote_led,
  output logic             o_addressed_led,
  output logic             o_keys_enable,
  output logic             o_lcl_clear_enable,
  output logic             o_entry_discard,
  output logic             o_meas_start,
  output logic             o_free_run,
  output logic      [19:0] o_src_hz,
  output logic      [15:0] o_src_mv,
  output logic      [3:0]  o_meas_func,
  output logic             o_lp80_on,
  output logic      [7:0]  o_srq_sel
);
  // refuse widths the byte-wide bus logic cannot serve
  if (DW != 8)
  begin
    $error("gii: data width must be 8");
  end
  // ----
  // apb decode
  // ----
  wire       apb_acc   = i_psel & i_penable;
  wire       apb_wr    = apb_acc & i_pwrite;
  wire       apb_rd    = apb_acc & ~i_pwrite;
  wire       hit_ctrl  = (i_paddr == GII_CTRL_OFS);
  wire       hit_stat  = (i_paddr == GII_STATUS_OFS);
  wire       hit_setup = (i_paddr == GII_SETUP_OFS);
  wire       hit_tx    = (i_paddr == GII_TXDAT_OFS);
  wire       hit_rx    = (i_paddr == GII_RXDAT_OFS);
  wire       hit_evt   = (i_paddr == GII_EVENT_OFS);
  wire       hit_any   = hit_ctrl | hit_stat | hit_setup | hit_tx
                       | hit_rx | hit_evt;
  logic [15:0] ctrl_reg;
  logic [7:0]  tx_reg;
  logic        tx_full_reg;
  logic [7:0]  rx_reg;
  logic        rx_full_reg;
  wire  [4:0]  my_addr  = ctrl_reg[GII_CTL_ADDR +: 5];
  wire         rdy_en   = ctrl_reg[GII_CTL_RDYEN];
  wire         err_en   = ctrl_reg[GII_CTL_ERREN];
  wire  [1:0]  trg_mode = ctrl_reg[GII_CTL_TRGM +: 2];
  // ----
  // command decode: only while atn true and ifc false
  // ----
  logic [7:0] dio_q;
  gii_sh_t    ah_state;
  gii_sh_t    sh_state;
  logic       listen_reg;
  logic       talk_reg;
  logic       remote_reg;
  logic       llo_reg;
  logic       spe_reg;
  logic       ren_q;
  wire  byte_in  = (ah_state == GII_SH_DAV) & i_dav;
  wire  cmd_in   = byte_in & i_atn & ~i_ifc;                  // R23
  wire  data_in  = byte_in & ~i_atn & listen_reg;
  wire  my_lad   = cmd_in & (i_dio == (GII_LAD_BASE | {3'h0, my_addr}));
  wire  my_tad   = cmd_in & (i_dio == (GII_TAD_BASE | {3'h0, my_addr}));
  wire  any_tad  = cmd_in & (i_dio[7:5] == 3'h2) & (i_dio != GII_CMD_UNT);
  wire  c_unl    = cmd_in & (i_dio == GII_CMD_UNL);
  wire  c_unt    = cmd_in & (i_dio == GII_CMD_UNT);
  wire  c_gtl    = cmd_in & (i_dio == GII_CMD_GTL) & listen_reg;
  wire  c_get    = cmd_in & (i_dio == GII_CMD_GET) & listen_reg;
  wire  c_sdc    = cmd_in & (i_dio == GII_CMD_SDC) & listen_reg;
  wire  c_dcl    = cmd_in & (i_dio == GII_CMD_DCL);
  wire  c_llo    = cmd_in & (i_dio == GII_CMD_LLO);
  wire  c_spe    = cmd_in & (i_dio == GII_CMD_SPE);
  wire  c_spd    = cmd_in & (i_dio == GII_CMD_SPD);
  // same clear for universal and addressed forms
  wire  do_clear = c_dcl | c_sdc;                              // R5
  // lockout blocks the local and clear keys too
  wire  lcl_key  = i_return_to_local_key & ~llo_reg & remote_reg; // R11
  wire  clr_key  = i_clear_key & ~llo_reg;                     // R11
  wire  ren_fall = ren_q & ~i_ren;
  // ----
  // remote/local state
  // ----
  wire  go_remote = i_ren & my_lad & ~remote_reg;             // R6
  wire  go_local  = remote_reg & (c_gtl | lcl_key | ren_fall); // R9 R12
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      remote_reg <= 1'b0;
      llo_reg    <= 1'b0;
      ren_q      <= 1'b0;
    end
    else
    begin
      ren_q <= i_ren;
      if (go_remote)
        remote_reg <= 1'b1;
      else if (go_local | ~i_ren)
        remote_reg <= 1'b0;
      if (do_clear | ~i_ren)
        llo_reg <= 1'b0;                                       // R4 R12
      else if (c_llo)
        llo_reg <= 1'b1;                                       // R11
    end
  end
  // remote keeps settings; only entry in progress is dropped
  assign o_entry_discard    = go_remote | go_local;           // R7 R9 R12
  assign o_keys_enable      = ~remote_reg & ~llo_reg;         // R7 R11
  assign o_lcl_clear_enable = ~llo_reg;                       // R11
  assign o_remote_led       = remote_reg;                     // R8
  assign o_addressed_led    = listen_reg | talk_reg;
  assign o_free_run = ~remote_reg | (trg_mode == GII_TRG_FREE); // R10
  // ----
  // addressed states; ifc drops both at once
  // ----
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      listen_reg <= 1'b0;
      talk_reg   <= 1'b0;
      spe_reg    <= 1'b0;
    end
    else if (i_ifc)
    begin
      listen_reg <= 1'b0;                                      // R20
      talk_reg   <= 1'b0;                                      // R20
      spe_reg    <= 1'b0;
    end
    else
    begin
      if (my_lad)
        listen_reg <= 1'b1;
      else if (c_unl | my_tad)
        listen_reg <= 1'b0;                                    // R24
      if (my_tad)
        talk_reg <= 1'b1;
      else if (c_unt | (any_tad & ~my_tad) | my_lad)
        talk_reg <= 1'b0;
      if (c_spe)
        spe_reg <= 1'b1;                                       // R16
      else if (c_spd)
        spe_reg <= 1'b0;                                       // R16
    end
  end
  // ----
  // trigger and clear presets
  // ----
  wire code_trg = data_in & i_settled_trigger_code;
  wire trig     = remote_reg & listen_reg & (c_get | code_trg); // R1 R2
  // remote clear key acts as a manual trigger when not locked out
  wire key_trg  = remote_reg & ~llo_reg & i_clear_key;
  logic        start_reg;
  logic [19:0] hz_reg;
  logic [15:0] mv_reg;
  logic [3:0]  func_reg;
  logic        lp_reg;
  logic [7:0]  sel_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      start_reg <= 1'b0;
      hz_reg    <= GII_SRC_HZ_RST;
      mv_reg    <= GII_SRC_MV_RST;
      func_reg  <= GII_MEAS_AC;
      lp_reg    <= GII_LP80_RST;
      sel_reg   <= GII_SRQSEL_DEF;
    end
    else
    begin
      start_reg <= trig | key_trg;                             // R1
      if (do_clear | (clr_key & ~remote_reg))
      begin
        hz_reg   <= GII_SRC_HZ_RST;                            // R3
        mv_reg   <= GII_SRC_MV_RST;                            // R3
        func_reg <= GII_MEAS_AC;                               // R3
        lp_reg   <= GII_LP80_RST;                              // R3
        sel_reg  <= GII_SRQSEL_RST;                            // R4
      end
      else if (apb_wr & hit_setup)
      begin
        hz_reg   <= i_pwdata[19:0];
        func_reg <= i_pwdata[23:20];
        lp_reg   <= i_pwdata[24];
        sel_reg  <= {i_pwdata[31:25], 1'b0};
      end
    end
  end
  assign o_meas_start = start_reg;
  assign o_src_hz     = hz_reg;
  assign o_src_mv     = mv_reg;
  assign o_meas_func  = func_reg;
  assign o_lp80_on    = lp_reg;
  assign o_srq_sel    = sel_reg;
  // ----
  // status byte: latched causes, rqs, service request
  // ----
  logic [2:0] cause_reg;
  wire  [2:0] cause_now = {i_invalid_code, i_inst_error & err_en,
                           i_meas_ready & rdy_en};             // R14 R15
  wire        sb_read   = spe_reg & talk_reg & (sh_state == GII_SH_WAIT)
                        & ~i_ndac;
  wire  [7:0] status_b  = {|cause_reg, 4'h0, cause_reg};       // R17
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cause_reg <= 3'h0;
    else if (do_clear)
      cause_reg <= 3'h0;                                       // R4
    else
      // a new cause wins over the read that would clear it
      cause_reg <= cause_now | (cause_reg & ~({3{sb_read}})); // R18
  end
  // request line held while any latched cause stands; no ppoll drive
  assign o_srq_oe = |cause_reg;                                // R14 R15 R19
  // ----
  // acceptor handshake (listener and commands)
  // ----
  wire ah_active = i_atn | (listen_reg & ~rx_full_reg);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ah_state    <= GII_SH_IDLE;
      dio_q       <= 8'h00;
      rx_reg      <= 8'h00;
      rx_full_reg <= 1'b0;
    end
    else
    begin
      case (ah_state)
        GII_SH_IDLE: if (ah_active & ~i_dav) ah_state <= GII_SH_DAV;
        GII_SH_DAV:  if (i_dav) ah_state <= GII_SH_WAIT;       // R25
        GII_SH_WAIT: if (~i_dav) ah_state <= GII_SH_IDLE;      // R25
        default:     ah_state <= GII_SH_IDLE;
      endcase
      if (byte_in)
        dio_q <= i_dio;
      if (data_in & ~i_settled_trigger_code)
      begin
        rx_reg      <= i_dio;
        rx_full_reg <= 1'b1;
      end
      else if (apb_rd & hit_rx)
        rx_full_reg <= 1'b0;
    end
  end
  // nrfd released only when ready; ndac released after byte taken
  assign o_nrfd_oe = (ah_active | listen_reg) & (ah_state != GII_SH_DAV);
  assign o_ndac_oe = (ah_active | listen_reg) & (ah_state != GII_SH_WAIT);
  // ----
  // source handshake (talker), status byte during serial poll
  // ----
  wire  talk_ok  = talk_reg & ~i_atn;                          // R21
  wire  have_b   = spe_reg | (tx_full_reg & ~i_blank_display); // R16 R22
  logic [7:0] out_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sh_state    <= GII_SH_IDLE;
      out_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      tx_full_reg <= 1'b0;
    end
    else
    begin
      case (sh_state)
        GII_SH_IDLE:
          if (talk_ok & have_b & ~i_nrfd)
          begin
            out_reg  <= spe_reg ? status_b : tx_reg;           // R16
            sh_state <= GII_SH_DAV;
          end
        GII_SH_DAV:  if (~talk_ok) sh_state <= GII_SH_IDLE;
                     else sh_state <= GII_SH_WAIT;             // R25
        GII_SH_WAIT:
          if (~talk_ok | ~i_ndac)
            sh_state <= GII_SH_IDLE;                           // R25
        default: sh_state <= GII_SH_IDLE;
      endcase
      if (apb_wr & hit_tx & ~tx_full_reg)
      begin
        tx_reg      <= i_pwdata[7:0];
        tx_full_reg <= 1'b1;
      end
      else if ((sh_state == GII_SH_WAIT) & ~i_ndac & ~spe_reg)
        tx_full_reg <= 1'b0;
      else if (tx_full_reg & i_blank_display)
        tx_full_reg <= 1'b0;                                   // R22
    end
  end
  // talker drives data and dav only; never atn/ifc/ren (no controller)
  assign o_dio    = out_reg;                                   // R13
  assign o_dio_oe = talk_ok & (sh_state != GII_SH_IDLE);
  assign o_dav_oe = talk_ok & (sh_state == GII_SH_WAIT);       // R25
  // ----
  // apb writes and read mux; zero wait states
  // ----
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ctrl_reg <= 16'h0000;
    else if (do_clear)
      ctrl_reg[GII_CTL_TRGM +: 2] <= GII_TRG_FREE;             // R3
    else if (apb_wr & hit_ctrl)
      ctrl_reg <= i_pwdata[15:0];
  end
  wire [31:0] evt_word = {24'h0, i_eoi, dio_q[6:0]};
  assign o_prdata = hit_ctrl  ? {16'h0, ctrl_reg} :
                    hit_stat  ? {16'h0, 2'h0, spe_reg, llo_reg, talk_reg,
                                 listen_reg, remote_reg, tx_full_reg,
                                 status_b} :
                    hit_setup ? {sel_reg[7:1], lp_reg, func_reg, hz_reg} :
                    hit_tx    ? {24'h0, tx_reg} :
                    hit_rx    ? {23'h0, rx_full_reg, rx_reg} :
                    hit_evt   ? evt_word : 32'h0;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc & ~hit_any;
endmodule

/* File: tb/gii_iface_properties.sv */
// port assertions for the instrument bus interface
`timescale 1ns/1ns
module gii_iface_props (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ren,
  input wire logic i_ifc,
  input wire logic i_invalid_code,
  input wire logic i_return_to_local_key,
  input wire logic o_remote_led,
  input wire logic o_lcl_clear_enable,
  input wire logic o_addressed_led,
  input wire logic o_dio_oe,
  input wire logic o_meas_start,
  input wire logic o_free_run,
  input wire logic o_srq_oe
);
  // ----
  // one clock domain; reset disables every check
  // ----
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // local key held while lockout is in force
  sequence s_locked_key;
    !o_lcl_clear_enable && o_remote_led && i_return_to_local_key;
  endsequence
  sequence s_bus_quiet;
    i_ren && !i_ifc;
  endsequence
  a_remote_needs_ren: assert property ($rose(o_remote_led) |-> $past(i_ren))
    else $error("remote entered without enable");
  a_ren_off_local: assert property (!i_ren |=> !o_remote_led)
    else $error("remote kept without enable");
  a_lockout_holds: assert property (s_locked_key ##0 s_bus_quiet |=> o_remote_led)
    else $error("local key acted under lockout");
  a_ifc_aborts: assert property (i_ifc |=> !o_addressed_led && !o_dio_oe)
    else $error("still addressed during abort");
  a_trigger_pulse: assert property (o_meas_start |=> !o_meas_start)
    else $error("measurement start longer than one cycle");
  a_local_free_run: assert property (!o_remote_led |-> o_free_run)
    else $error("local without free run");
  a_invalid_srq: assert property ($rose(i_invalid_code) |-> ##[1:3] o_srq_oe)
    else $error("no service request on invalid code");
  a_talk_addressed: assert property (o_dio_oe |-> o_addressed_led)
    else $error("data driven while not addressed");
endmodule

bind gii_ieee488_instrument_interface gii_iface_props u_props (
  .i_clk, .i_nrst, .i_ren, .i_ifc, .i_invalid_code, .i_return_to_local_key,
  .o_remote_led, .o_lcl_clear_enable, .o_addressed_led, .o_dio_oe,
  .o_meas_start, .o_free_run, .o_srq_oe
);

/* File: tb/gii_ctl_model.sv */
// controller model on the far side of the instrument bus
`timescale 1ns/1ns
module gii_ctl_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dio,
  input  wire logic       i_dio_oe,
  input  wire logic       i_dav_oe,
  input  wire logic       i_nrfd_oe,
  input  wire logic       i_ndac_oe,
  output logic      [7:0] o_dio,
  output logic            o_dav,
  output logic            o_nrfd,
  output logic            o_ndac,
  output logic            o_atn,
  output logic            o_ifc,
  output logic            o_ren,
  output logic            o_eoi
);
  logic [7:0] c_dio = 8'h00;
  logic       c_dav = 1'b0, c_nrfd = 1'b0, c_ndac = 1'b0;
  logic       c_atn = 1'b0, c_ifc = 1'b0, c_ren = 1'b0;
  // ----
  // wired-or lines; a released line floats false via its pull-up
  // ----
  assign o_dio  = c_dio | (i_dio_oe ? i_dio : 8'h00);
  assign o_dav  = c_dav | i_dav_oe;
  assign o_nrfd = c_nrfd | i_nrfd_oe;
  assign o_ndac = c_ndac | i_ndac_oe;
  assign o_atn  = c_atn;
  assign o_ifc  = c_ifc;
  assign o_ren  = c_ren;
  assign o_eoi  = 1'b0; // no end marks, so eoi logic stays unexercised
  // source: data settles a cycle before dav, dav held until accepted
  task automatic send(input logic a, input logic [7:0] b, output logic ok);
    int k, j;
    c_atn <= a;
    c_nrfd <= 1'b0;
    c_ndac <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 64 && o_nrfd !== 1'b0; k++) @(posedge i_clk);
    c_dio <= b;
    @(posedge i_clk);
    c_dav <= 1'b1;
    @(posedge i_clk);
    for (j = 0; j < 64 && o_ndac !== 1'b0; j++) @(posedge i_clk);
    c_dav <= 1'b0;
    c_dio <= 8'h00;
    @(posedge i_clk);
    ok = k < 64 && j < 64;
  endtask
  // acceptor: take the byte on dav, accept, wait for dav release
  task automatic recv(output logic [7:0] b, output logic ok);
    int k, j;
    c_atn <= 1'b0;
    c_ndac <= 1'b1;
    @(posedge i_clk);
    for (k = 0; k < 64 && o_dav !== 1'b1; k++) @(posedge i_clk);
    b = o_dio;
    c_nrfd <= 1'b1; // not ready again, so no second byte starts
    c_ndac <= 1'b0;
    @(posedge i_clk);
    for (j = 0; j < 64 && o_dav !== 1'b0; j++) @(posedge i_clk);
    ok = k < 64 && j < 64;
  endtask
endmodule

/* File: tb/gii_ieee488_instrument_interface_bench.sv */
// self-checking bench for the instrument bus interface
`timescale 1ns/1ns
module gii_ieee488_instrument_interface_bench;
  import gii_pkg::*;
  localparam logic [7:0]  ADR = 8'h05; // any valid bus address
  localparam logic [7:0]  LAD = GII_LAD_BASE | ADR;
  localparam logic [7:0]  SB_RDY = 8'((1 << GII_SB_RQS) | (1 << GII_SB_READY));
  localparam logic [31:0] HOLD = ({30'h0, GII_TRG_HOLD} << GII_CTL_TRGM) | ADR;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_return_to_local_key = 1'b0;
  logic        i_meas_ready = 1'b0, i_invalid_code = 1'b0;
  logic        i_settled_trigger_code = 1'b0, i_inst_error = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic [19:0] o_src_hz;
  logic [15:0] o_src_mv;
  logic [7:0]  i_dio, o_dio, o_srq_sel, sb;
  logic [3:0]  o_meas_func;
  logic        o_pready, o_pslverr, o_dio_oe, i_dav, o_dav_oe, i_nrfd;
  logic        o_nrfd_oe, i_ndac, o_ndac_oe, i_atn, i_ifc, i_ren, i_eoi;
  logic        o_srq_oe, o_remote_led, o_addressed_led, o_keys_enable;
  logic        o_lcl_clear_enable, o_entry_discard, o_meas_start;
  logic        o_free_run, o_lp80_on, e, ok;
  int          num_errors = 0, n_checks = 0, n_trig = 0, n_disc = 0, i;
  always #10 i_clk = ~i_clk;
  // clear, other key and blank display held idle
  gii_ieee488_instrument_interface u_dut (
    .i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_dio, .o_dio, .o_dio_oe, .i_dav,
    .o_dav_oe, .i_nrfd, .o_nrfd_oe, .i_ndac, .o_ndac_oe, .i_atn, .i_ifc,
    .i_ren, .i_eoi, .o_srq_oe, .i_return_to_local_key, .i_clear_key(1'b0),
    .i_other_key(1'b0), .i_meas_ready, .i_inst_error, .i_invalid_code,
    .i_settled_trigger_code, .i_blank_display(1'b0), .o_remote_led,
    .o_addressed_led, .o_keys_enable, .o_lcl_clear_enable, .o_entry_discard,
    .o_meas_start, .o_free_run, .o_src_hz, .o_src_mv, .o_meas_func,
    .o_lp80_on, .o_srq_sel);
  gii_ctl_model u_ctl (
    .i_clk, .i_dio(o_dio), .i_dio_oe(o_dio_oe), .i_dav_oe(o_dav_oe),
    .i_nrfd_oe(o_nrfd_oe), .i_ndac_oe(o_ndac_oe), .o_dio(i_dio),
    .o_dav(i_dav), .o_nrfd(i_nrfd), .o_ndac(i_ndac), .o_atn(i_atn),
    .o_ifc(i_ifc), .o_ren(i_ren), .o_eoi(i_eoi));
  // pulse counters, since start and discard last one cycle
  always @(posedge i_clk)
  begin
    if (o_meas_start === 1'b1) n_trig++;
    if (o_entry_discard === 1'b1) n_disc++;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cb(input string n, input logic x, input logic g);
    chk(n, {31'h0, x}, {31'h0, g});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    for (k = 0; k < 32 && o_pready !== 1'b1; k++) @(posedge i_clk);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    cb("pready", 1'b1, k < 32);
    if (k >= 32) close_out();
  endtask
  task automatic put(input logic a, input logic [7:0] b);
    u_ctl.send(a, b, ok);
    cb("handshake", 1'b1, ok);
    if (!ok) close_out();
  endtask
  // serial poll, always closed by disable and untalk
  task automatic poll(input logic [7:0] x);
    put(1'b1, GII_CMD_SPE);
    put(1'b1, GII_TAD_BASE | ADR);
    u_ctl.recv(sb, ok);
    chk("status byte", {23'h0, 1'b1, x}, {23'h0, ok, sb});
    if (!ok) close_out();
    put(1'b1, GII_CMD_SPD);
    put(1'b1, GII_CMD_UNT);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    num_errors++;
    close_out();
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b1, GII_CTRL_OFS, {24'h0, ADR});
    apb(1'b0, GII_CTRL_OFS, 32'h0);
    chk("ctrl", {24'h0, ADR}, q);
    apb(1'b0, 8'h3C, 32'h0);
    cb("unmapped", 1'b1, e);
    u_ctl.c_ren <= 1'b1;
    put(1'b1, GII_CMD_UNL);
    cb("enabled only", 1'b0, o_remote_led);
    put(1'b1, LAD);
    cb("remote", 1'b1, o_remote_led);
    cb("keys", 1'b0, o_keys_enable);
    put(1'b1, GII_CMD_GET);
    chk("bus trigger", 32'h1, n_trig);
    i_settled_trigger_code <= 1'b1;
    put(1'b0, 8'h33);
    i_settled_trigger_code <= 1'b0;
    chk("code trigger", 32'h2, n_trig);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, GII_CTRL_OFS, HOLD);
      apb(1'b1, GII_SETUP_OFS, 32'h202007D0);
      put(1'b1, i ? GII_CMD_DCL : GII_CMD_SDC);
      chk("hz", {12'h0, GII_SRC_HZ_RST}, {12'h0, o_src_hz});
      chk("mv lp", {GII_SRC_MV_RST, GII_LP80_RST}, {o_src_mv, o_lp80_on});
      chk("func", {28'h0, GII_MEAS_AC}, {28'h0, o_meas_func});
      cb("free run", 1'b1, o_free_run);
      chk("srq sel", {24'h0, GII_SRQSEL_RST}, {24'h0, o_srq_sel});
    end
    put(1'b1, GII_CMD_LLO);
    cb("lockout", 1'b0, o_lcl_clear_enable);
    i_return_to_local_key <= 1'b1;
    wt(3);
    cb("key locked", 1'b1, o_remote_led);
    i_return_to_local_key <= 1'b0;
    u_ctl.c_ren <= 1'b0;
    apb(1'b1, GII_CTRL_OFS, HOLD);
    chk("ren off", 32'h1, {30'h0, o_remote_led, o_lcl_clear_enable});
    cb("local trigger", 1'b1, o_free_run);
    u_ctl.c_ren <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      put(1'b1, LAD);
      cb("hold in remote", 1'b0, o_free_run);
      if (i == 0)
        put(1'b1, GII_CMD_GTL);
      i_return_to_local_key <= (i == 1);
      wt(3);
      i_return_to_local_key <= 1'b0;
      cb("back to local", 1'b0, o_remote_led);
    end
    chk("entry discard", 32'h6, n_disc);
    apb(1'b1, GII_CTRL_OFS, {24'h0, ADR});
    i_invalid_code <= 1'b1;
    i_meas_ready <= 1'b1;
    wt(4);
    i_invalid_code <= 1'b0;
    cb("srq invalid", 1'b1, o_srq_oe);
    i_meas_ready <= 1'b0;
    put(1'b1, GII_CMD_DCL);
    cb("srq withdrawn", 1'b0, o_srq_oe);
    poll(8'h00);
    i_meas_ready <= 1'b1;
    i_inst_error <= 1'b1;
    wt(4);
    cb("ready masked", 1'b0, o_srq_oe);
    i_inst_error <= 1'b0;
    apb(1'b1, GII_CTRL_OFS, (32'h1 << GII_CTL_RDYEN) | ADR);
    wt(2);
    cb("ready srq", 1'b1, o_srq_oe);
    poll(SB_RDY);
    i_meas_ready <= 1'b0;
    poll(SB_RDY);
    cb("srq released", 1'b0, o_srq_oe);
    poll(8'h00);
    apb(1'b1, GII_TXDAT_OFS, 32'hA5);
    put(1'b1, GII_TAD_BASE | ADR);
    u_ctl.recv(sb, ok);
    chk("talk byte", 32'h1A5, {23'h0, ok, sb});
    if (!ok) close_out();
    put(1'b1, GII_CMD_UNT);
    put(1'b1, LAD);
    cb("listening", 1'b1, o_addressed_led);
    u_ctl.c_ifc <= 1'b1;
    wt(2);
    cb("abort", 1'b0, o_addressed_led);
    u_ctl.c_ifc <= 1'b0;
    close_out();
  end
endmodule
